// >>> common/dwr_pkg.sv
// Package for the drive warning and access register block.
// Assumes one system clock; register offsets are byte addresses.
`default_nettype none
package dwr_pkg;
   localparam logic [15:0] OFS_CHANNEL_LOCK = 16'h013c;
   localparam logic [15:0] OFS_ABS_NEEDS_HOMING = 16'h062c;
   localparam logic [15:0] OFS_ANALOG_IN1 = 16'h0902;
   localparam logic [15:0] OFS_STORED_WARN = 16'h1c18;
   localparam logic [15:0] OFS_ACTIVE_WARN = 16'h1c16;
   localparam logic [15:0] RST_CHANNEL_LOCK = 16'h0000;
   localparam logic [15:0] RST_ABS_NEEDS_HOMING = 16'h0000;
   localparam logic [15:0] RST_WARN = 16'h0000;
   // Bits 3, 14, 15 reserved
   localparam logic [15:0] WARN_VALID_MASK = 16'h3ff7;
   // Bits 10, 11, 13 follow their cause
   localparam logic [15:0] WARN_SELF_CLEAR_MASK = 16'h2c00;
   localparam int BIT_GENERAL = 0;
   localparam int BIT_AMP_TEMP = 1;
   localparam int BIT_MOTOR_TEMP = 2;
   localparam int BIT_OVL_AMP = 4;
   localparam int BIT_OVL_MOTOR = 5;
   localparam int BIT_OVL_BRAKE = 6;
   localparam int BIT_CAN = 7;
   localparam int BIT_ENCODER = 8;
   localparam int BIT_RS485 = 9;
   localparam int BIT_POWER_EN = 10;
   localparam int BIT_UNDERVOLT = 11;
   localparam int BIT_PROFIBUS = 12;
   localparam int BIT_POS_INVALID = 13;
   localparam logic signed [15:0] ANA_MIN_MV = -16'sd10000;
   localparam logic signed [15:0] ANA_MAX_MV = 16'sd10000;
   localparam int SYNC_STAGES = 3;

   typedef struct packed {
      logic general;
      logic amp_temp;
      logic motor_temp;
      logic ovl_amp;
      logic ovl_motor;
      logic ovl_brake;
      logic can;
      logic encoder;
      logic rs485;
      logic undervolt;
      logic profibus;
      logic pos_invalid;
   } dwr_cause_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dwr_req_t;
endpackage
`default_nettype wire

// >>> verilog/dwr_sync.sv
// Three-stage synchroniser with agreement of stages two and three.
// Assumes asynchronous pin inputs; output holds until stages agree.
`default_nettype none
module dwr_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Data
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out,
   // Power-up value
   input wire logic [WIDTH-1:0] init_val
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;

   if (WIDTH < 1)
   begin : g_bad_width
      $error("dwr_sync width must be positive");
   end

   always_ff @(posedge sys_clk)
   begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end

   // Bitwise: a bit changes only once two stages agree
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         sync_out <= init_val;
      else
         sync_out <= (s2_q & s3_q) | (sync_out & (s2_q | s3_q));
   end
endmodule // dwr_sync
`default_nettype wire

// >>> verilog/dwr_regs.sv
// Warning, homing-gate, channel lock and analogue register block.
// Assumes causes come from same-clock monitors; only pins synchronised.
//
// Operation
// RULE1: Sixteen bit stored warnings stay set once occurred
// RULE2: Fault clear command clears all stored bits; code keeps bits whose cause is active in the clear cycle
// RULE3: Bits 10, 11, 13 self clear
// RULE4: Bits 0-2, 4-6 temperatures and overloads
// RULE5: Bits 7, 8, 9, 12 comms and encoder
// RULE6: Bits 10, 11, 13 power, undervoltage, position
// RULE7: Reserved bits 3, 14, 15 read zero
// RULE8: Live active warning vector, same layout
// RULE9: Homing setting gates absolute positioning
// RULE10: Lock rejects commissioning, panel, second fieldbus
// RULE11: Lock clear accepts all channels
// RULE12: Hardware inputs processed regardless of lock
// RULE13: Analogue input one in signed millivolts
`default_nettype none
module dwr_regs (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Primary fieldbus register access
   input wire dwr_pkg::dwr_req_t fb_req,
   output logic [15:0] fb_rdata_q,
   output logic fb_ack_q,
   output logic fb_err_q,
   // Other channels: commissioning, panel, second fieldbus
   input wire dwr_pkg::dwr_req_t sec_req,
   output logic [15:0] sec_rdata_q,
   output logic sec_ack_q,
   output logic sec_rejected_q,
   // Warning causes and commands
   input wire dwr_pkg::dwr_cause_t warn_cause,
   input wire logic fault_clear_command,
   input wire logic power_stage_enable_a,
   input wire logic power_stage_enable_b,
   input wire logic halt_in,
   // Analogue input one, raw millivolts
   input wire logic signed [15:0] analog_input_one,
   // Positioning gate
   input wire logic homing_done,
   input wire logic abs_move_req,
   output logic abs_move_allowed_q,
   output logic abs_move_refused_q,
   output logic halt_q,
   // Status
   output logic [15:0] stored_warning_vector_q,
   output logic [15:0] active_warning_vector_q,
   output logic channel_lock_q
);
   logic [2:0] pins_s;
   logic [15:0] active_d;
   logic [15:0] abs_home_q;
   logic signed [15:0] analog_in1_voltage_q;
   logic fb_hit;
   logic sec_ok;

   function automatic logic [15:0] rd_mux(input logic [15:0] a,
      input logic [15:0] lock, input logic [15:0] home,
      input logic [15:0] ana, input logic [15:0] stw,
      input logic [15:0] acw);
      case (a)
         dwr_pkg::OFS_CHANNEL_LOCK: rd_mux = lock;
         dwr_pkg::OFS_ABS_NEEDS_HOMING: rd_mux = home;
         dwr_pkg::OFS_ANALOG_IN1: rd_mux = ana;
         dwr_pkg::OFS_STORED_WARN: rd_mux = stw;
         dwr_pkg::OFS_ACTIVE_WARN: rd_mux = acw;
         default: rd_mux = 16'h0000;
      endcase
   endfunction

   function automatic logic mapped(input logic [15:0] a);
      mapped = (a == dwr_pkg::OFS_CHANNEL_LOCK)
         || (a == dwr_pkg::OFS_ABS_NEEDS_HOMING)
         || (a == dwr_pkg::OFS_ANALOG_IN1)
         || (a == dwr_pkg::OFS_STORED_WARN)
         || (a == dwr_pkg::OFS_ACTIVE_WARN);
   endfunction

   // Enable pins and halt are pins: synchronise
   // Power-up: enables idle high, halt idle low, so no false halt
   dwr_sync #(
      .WIDTH(3)
   ) u_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .async_in({halt_in, power_stage_enable_b, power_stage_enable_a}),
      .sync_out(pins_s),
      .init_val(3'b011)
   );

   always_comb
   begin
      active_d = 16'h0000;
      active_d[dwr_pkg::BIT_GENERAL] = warn_cause.general; // RULE4
      active_d[dwr_pkg::BIT_AMP_TEMP] = warn_cause.amp_temp; // RULE4
      active_d[dwr_pkg::BIT_MOTOR_TEMP] = warn_cause.motor_temp; // RULE4
      active_d[dwr_pkg::BIT_OVL_AMP] = warn_cause.ovl_amp; // RULE4
      active_d[dwr_pkg::BIT_OVL_MOTOR] = warn_cause.ovl_motor; // RULE4
      active_d[dwr_pkg::BIT_OVL_BRAKE] = warn_cause.ovl_brake; // RULE4
      active_d[dwr_pkg::BIT_CAN] = warn_cause.can; // RULE5
      active_d[dwr_pkg::BIT_ENCODER] = warn_cause.encoder; // RULE5
      active_d[dwr_pkg::BIT_RS485] = warn_cause.rs485; // RULE5
      active_d[dwr_pkg::BIT_PROFIBUS] = warn_cause.profibus; // RULE5
      active_d[dwr_pkg::BIT_POWER_EN] = ~(pins_s[0] & pins_s[1]); // RULE6
      active_d[dwr_pkg::BIT_UNDERVOLT] = warn_cause.undervolt; // RULE6
      active_d[dwr_pkg::BIT_POS_INVALID] = warn_cause.pos_invalid; // RULE6
      active_d = active_d & dwr_pkg::WARN_VALID_MASK; // RULE7
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         active_warning_vector_q <= dwr_pkg::RST_WARN;
      else
         active_warning_vector_q <= active_d; // RULE8
   end

   // New warnings win over a clear in the same cycle
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         stored_warning_vector_q <= dwr_pkg::RST_WARN;
      else if (fault_clear_command)
         stored_warning_vector_q <= active_d; // RULE2
      else
         stored_warning_vector_q <= active_d // RULE1
            | (stored_warning_vector_q
               & ~dwr_pkg::WARN_SELF_CLEAR_MASK); // RULE3
   end

   assign fb_hit = fb_req.wr || fb_req.rd;
   assign sec_ok = !channel_lock_q; // RULE11

   // Primary fieldbus writes settings; read-only targets ignore data
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         channel_lock_q <= dwr_pkg::RST_CHANNEL_LOCK[0];
         abs_home_q <= dwr_pkg::RST_ABS_NEEDS_HOMING;
      end
      else if (fb_req.wr)
      begin
         if (fb_req.addr == dwr_pkg::OFS_CHANNEL_LOCK)
            channel_lock_q <= fb_req.wdata[0];
         else if (fb_req.addr == dwr_pkg::OFS_ABS_NEEDS_HOMING)
            abs_home_q <= {15'h0000, fb_req.wdata[0]};
      end
      else if (sec_req.wr && sec_ok
               && sec_req.addr == dwr_pkg::OFS_ABS_NEEDS_HOMING)
         abs_home_q <= {15'h0000, sec_req.wdata[0]};
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         fb_ack_q <= 1'b0;
         fb_err_q <= 1'b0;
         fb_rdata_q <= 16'h0000;
      end
      else
      begin
         fb_ack_q <= fb_hit;
         fb_err_q <= fb_hit && !mapped(fb_req.addr);
         fb_rdata_q <= fb_req.rd ? rd_mux(fb_req.addr,
            {15'h0000, channel_lock_q}, abs_home_q,
            analog_in1_voltage_q, stored_warning_vector_q,
            active_warning_vector_q) : 16'h0000;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         sec_ack_q <= 1'b0;
         sec_rejected_q <= 1'b0;
         sec_rdata_q <= 16'h0000;
      end
      else
      begin
         sec_ack_q <= (sec_req.wr || sec_req.rd) && sec_ok; // RULE11
         sec_rejected_q <= (sec_req.wr || sec_req.rd) && !sec_ok; // RULE10
         sec_rdata_q <= (sec_req.rd && sec_ok) ? rd_mux(sec_req.addr,
            {15'h0000, channel_lock_q}, abs_home_q,
            analog_in1_voltage_q, stored_warning_vector_q,
            active_warning_vector_q) : 16'h0000;
      end
   end

   // Clamp to documented span
   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
         analog_in1_voltage_q <= 16'sh0000;
      else if (analog_input_one > dwr_pkg::ANA_MAX_MV)
         analog_in1_voltage_q <= dwr_pkg::ANA_MAX_MV; // RULE13
      else if (analog_input_one < dwr_pkg::ANA_MIN_MV)
         analog_in1_voltage_q <= dwr_pkg::ANA_MIN_MV; // RULE13
      else
         analog_in1_voltage_q <= analog_input_one; // RULE13
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         abs_move_allowed_q <= 1'b0;
         abs_move_refused_q <= 1'b0;
         halt_q <= 1'b0;
      end
      else
      begin
         abs_move_allowed_q <= abs_move_req
            && (!abs_home_q[0] || homing_done); // RULE9
         abs_move_refused_q <= abs_move_req
            && abs_home_q[0] && !homing_done; // RULE9
         halt_q <= pins_s[2]; // RULE12
      end
   end
endmodule // dwr_regs
`default_nettype wire

// >>> verif/dwr_regs_properties.sv
// Concurrent checks on the warning and access register block.
// Assumes it is bound onto dwr_regs and sees only its ports.
`default_nettype none
module dwr_regs_properties (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Other channels
   input wire dwr_pkg::dwr_req_t sec_req,
   input wire logic sec_ack_q,
   input wire logic sec_rejected_q,
   input wire logic channel_lock_q,
   // Warnings and pins
   input wire dwr_pkg::dwr_cause_t warn_cause,
   input wire logic fault_clear_command,
   input wire logic power_stage_enable_a,
   input wire logic power_stage_enable_b,
   input wire logic halt_in,
   input wire logic halt_q,
   input wire logic homing_done,
   input wire logic abs_move_req,
   input wire logic abs_move_allowed_q,
   input wire logic [15:0] stored_warning_vector_q,
   input wire logic [15:0] active_warning_vector_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   logic [15:0] kept;
   logic sec_any;
   // Self-clearing bits are left out of the sticky view
   assign kept = stored_warning_vector_q & ~dwr_pkg::WARN_SELF_CLEAR_MASK;
   assign sec_any = sec_req.wr || sec_req.rd;
   a_sticky_bits: assert property (!fault_clear_command |=>
      (kept & $past(kept)) == $past(kept)) else $error("stored bit lost");
   a_clear_all: assert property (fault_clear_command &&
      warn_cause == '0 |=> kept == 16'h0000) else $error("clear failed");
   a_brake_bit: assert property (warn_cause.ovl_brake |=>
      stored_warning_vector_q[6] && active_warning_vector_q[6])
      else $error("bit 6 missing");
   a_power_bit: assert property (!power_stage_enable_a [*8] |->
      active_warning_vector_q[10]) else $error("bit 10 missing");
   a_enable_b_bit: assert property (!power_stage_enable_b [*8] |->
      active_warning_vector_q[10]) else $error("bit 10 missing for b");
   a_lock_rejects: assert property (sec_any && channel_lock_q |=>
      sec_rejected_q) else $error("locked access not rejected");
   a_lock_open: assert property (sec_any && !channel_lock_q |=>
      sec_ack_q && !sec_rejected_q) else $error("open access refused");
   a_homed_move: assert property (abs_move_req && homing_done |=>
      abs_move_allowed_q) else $error("homed move refused");
   a_halt_follows: assert property ($stable(halt_in) [*8] |->
      halt_q == halt_in) else $error("halt not followed");
endmodule // dwr_regs_properties
bind dwr_regs dwr_regs_properties u_props (.sys_clk, .resetn, .sec_req,
   .sec_ack_q, .sec_rejected_q, .channel_lock_q, .warn_cause,
   .fault_clear_command, .power_stage_enable_a, .power_stage_enable_b,
   .halt_in, .halt_q,
   .homing_done, .abs_move_req, .abs_move_allowed_q,
   .stored_warning_vector_q, .active_warning_vector_q);
`default_nettype wire

// >>> verif/dwr_fb_master.sv
// Fieldbus master model on the primary register channel.
// Assumes one answer per request, one cycle after it is taken.
`default_nettype none
module dwr_fb_master (
   // Clock
   input wire logic sys_clk,
   // Register channel
   output var dwr_pkg::dwr_req_t fb_req,
   input wire logic [15:0] fb_rdata_q,
   input wire logic fb_ack_q,
   input wire logic fb_err_q
);
   timeunit 1ns;
   timeprecision 1ps;
   initial fb_req = '0;
   task automatic xfer(input logic wr, input logic [15:0] a, d,
      output logic [15:0] q, output logic e);
      int n;
      @(posedge sys_clk);
      fb_req <= '{wr, !wr, a, d};
      @(posedge sys_clk);
      // Released lines show garbage, never the last value
      fb_req <= '{1'b0, 1'b0, ~a, ~d};
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (!fb_ack_q && n < 4);
      q = fb_rdata_q;
      e = fb_ack_q ? fb_err_q : 1'b1;
   endtask
endmodule // dwr_fb_master
`default_nettype wire

// >>> verif/dwr_regs_tb.sv
// Self-checking bench for the warning and access register block.
// Assumes the fieldbus master model and the bound checker.
`default_nettype none
module dwr_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   dwr_pkg::dwr_req_t fb_req;
   dwr_pkg::dwr_req_t sec_req = '0;
   dwr_pkg::dwr_cause_t warn_cause = '0;
   logic fault_clear_command = 1'b0;
   logic power_stage_enable_a = 1'b1;
   logic power_stage_enable_b = 1'b1;
   logic halt_in = 1'b0;
   logic homing_done = 1'b0;
   logic abs_move_req = 1'b0;
   logic signed [15:0] analog_input_one = 16'h0000;
   logic [15:0] fb_rdata_q, sec_rdata_q, stored_warning_vector_q;
   logic [15:0] active_warning_vector_q, q;
   logic fb_ack_q, fb_err_q, sec_ack_q, sec_rejected_q, e;
   logic abs_move_allowed_q, abs_move_refused_q, halt_q, channel_lock_q;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   localparam int pos[12] = '{0, 1, 2, 4, 5, 6, 7, 8, 9, 11, 12, 13};
   localparam logic [15:0] ain[3] = '{16'h2ee0, 16'hd120, 16'h04d2};
   localparam logic [15:0] aout[3] = '{16'h2710, 16'hd8f0, 16'h04d2};
   dwr_regs uut (.sys_clk, .resetn, .fb_req, .fb_rdata_q, .fb_ack_q,
      .fb_err_q, .sec_req, .sec_rdata_q, .sec_ack_q, .sec_rejected_q,
      .warn_cause, .fault_clear_command, .power_stage_enable_a,
      .power_stage_enable_b, .halt_in, .analog_input_one,
      .homing_done, .abs_move_req, .abs_move_allowed_q,
      .abs_move_refused_q, .halt_q, .stored_warning_vector_q,
      .active_warning_vector_q, .channel_lock_q);
   dwr_fb_master mst (.sys_clk, .fb_req, .fb_rdata_q, .fb_ack_q, .fb_err_q);
   always #2 sys_clk = ~sys_clk;
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic chk(input string n, input logic [15:0] x, g);
      checks_done++;
      if (g !== x)
      begin
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
         bad_count++;
      end
   endtask
   task automatic rd(input logic [15:0] a, x, input string n);
      mst.xfer(1'b0, a, 16'h0000, q, e);
      chk(n, x, q);
   endtask
   task automatic sec_wr(input logic [15:0] a, d, input logic rej);
      @(posedge sys_clk);
      sec_req <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk);
      sec_req <= '{1'b0, 1'b0, ~a, ~d};
      @(posedge sys_clk);
      chk("sec rejected", {15'h0, rej}, {15'h0, sec_rejected_q});
      chk("sec ack", {15'h0, !rej}, {15'h0, sec_ack_q});
   endtask
   task automatic sec_rd(input logic [15:0] a, x);
      @(posedge sys_clk);
      sec_req <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge sys_clk);
      sec_req <= '{1'b0, 1'b0, ~a, 16'hffff};
      @(posedge sys_clk);
      chk("sec rdata", x, sec_rdata_q);
   endtask
   task automatic t_regs();
      rd(16'h013c, 16'h0000, "lock reset");
      rd(16'h062c, 16'h0000, "homing reset");
      mst.xfer(1'b1, 16'h1c18, 16'hffff, q, e);
      rd(16'h1c18, 16'h0000, "stored read only");
      rd(16'h0000, 16'h0000, "unmapped data");
      chk("unmapped err", 16'h0001, {15'h0, e});
      $display("regs done");
   endtask
   task automatic t_warn();
      for (int i = 0; i < 12; i++)
      begin
         @(posedge sys_clk);
         warn_cause <= dwr_pkg::dwr_cause_t'(12'h800 >> i);
         repeat (2) @(posedge sys_clk);
         chk("act", 16'h0001 << pos[i], active_warning_vector_q);
         warn_cause <= '0;
      end
      repeat (2) @(posedge sys_clk);
      chk("stored", 16'h13f7, stored_warning_vector_q);
      power_stage_enable_a <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk("pin set", 16'h17f7, stored_warning_vector_q);
      power_stage_enable_a <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk("pin gone", 16'h13f7, stored_warning_vector_q);
      power_stage_enable_b <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk("pin b set", 16'h17f7, stored_warning_vector_q);
      rd(16'h1c16, 16'h0400, "active bus");
      power_stage_enable_b <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk("pin b gone", 16'h13f7, stored_warning_vector_q);
      // Cause present during the clear must survive it
      warn_cause <= dwr_pkg::dwr_cause_t'(12'h020);
      fault_clear_command <= 1'b1;
      @(posedge sys_clk);
      warn_cause <= '0;
      fault_clear_command <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("set wins", 16'h0080, stored_warning_vector_q);
      fault_clear_command <= 1'b1;
      @(posedge sys_clk);
      fault_clear_command <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk("cleared", 16'h0000, stored_warning_vector_q);
      $display("warn done");
   endtask
   task automatic t_lock();
      mst.xfer(1'b1, 16'h013c, 16'h0001, q, e);
      chk("lock", 16'h0001, {15'h0, channel_lock_q});
      sec_wr(16'h062c, 16'h0001, 1'b1);
      rd(16'h062c, 16'h0000, "locked write");
      sec_rd(16'h013c, 16'h0000);
      halt_in <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk("halt", 16'h0001, {15'h0, halt_q});
      halt_in <= 1'b0;
      mst.xfer(1'b1, 16'h013c, 16'h0000, q, e);
      sec_wr(16'h062c, 16'h0001, 1'b0);
      rd(16'h062c, 16'h0001, "open write");
      sec_rd(16'h062c, 16'h0001);
      $display("lock done");
   endtask
   task automatic t_move();
      abs_move_req <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("refused", 16'h0001, {15'h0, abs_move_refused_q});
      homing_done <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("homed", 16'h0001, {15'h0, abs_move_allowed_q});
      homing_done <= 1'b0;
      mst.xfer(1'b1, 16'h062c, 16'h0000, q, e);
      repeat (2) @(posedge sys_clk);
      chk("free", 16'h0001, {15'h0, abs_move_allowed_q});
      abs_move_req <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
         analog_input_one <= ain[i];
         repeat (2) @(posedge sys_clk);
         rd(16'h0902, aout[i], "analog");
      end
      $display("move done");
   endtask
   initial
   begin
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      t_regs();
      t_warn();
      t_lock();
      t_move();
      give_verdict();
   end
endmodule // dwr_regs_tb
`default_nettype wire
